//--- vcc_pkg.sv
// package of constants and types for the vector compare and control read block
package vcc_pkg;
    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int VEC_W = 128;
    localparam int GPR_W = 32;
    localparam int IMM_W = 5;
    localparam int SEL_W = 5;
    localparam logic [GPR_W-1:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [GPR_W-1:0] CSR_RST = 32'h0000_0000;
    // bit of the implementation register that says partitioning is present
    localparam int PART_BIT = 17;
    // ----------------------------------------------------------------
    // control register selectors
    // ----------------------------------------------------------------
    localparam logic [SEL_W-1:0] SEL_INFO = 5'h00;
    localparam logic [SEL_W-1:0] SEL_CSR = 5'h01;
    localparam logic [SEL_W-1:0] SEL_ACCESS = 5'h02;
    localparam logic [SEL_W-1:0] SEL_SAVE = 5'h03;
    localparam logic [SEL_W-1:0] SEL_MODIFY = 5'h04;
    localparam logic [SEL_W-1:0] SEL_REQUEST = 5'h05;
    localparam logic [SEL_W-1:0] SEL_MAP = 5'h06;
    localparam logic [SEL_W-1:0] SEL_UNMAP = 5'h07;
    // lane data formats
    typedef enum logic [1:0] {
        FMT_BYTE = 2'h0,
        FMT_HALF = 2'h1,
        FMT_WORD = 2'h2,
        FMT_DOUBLE = 2'h3
    } vcc_fmt_t;
    // compare operations
    typedef enum logic [2:0] {
        OP_EQ_IMM = 3'h0,
        OP_CLE_S = 3'h1,
        OP_CLE_U = 3'h2,
        OP_LE_S_IMM = 3'h3,
        OP_LE_U_IMM = 3'h4,
        OP_LT_S = 3'h5
    } vcc_op_t;
    // read path states, one-hot
    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DONE = 2'b10
    } vcc_rd_state_t;
endpackage

//--- vcc_cmp_if.sv
// interface carrying one compare request and its result between modules
`timescale 1ns/1ps
`default_nettype none
interface vcc_cmp_if;
    import vcc_pkg::*;
    logic [VEC_W-1:0] src_a;
    logic [VEC_W-1:0] src_b;
    logic [IMM_W-1:0] imm;
    vcc_op_t op;
    vcc_fmt_t fmt;
    logic [VEC_W-1:0] result;
    modport top (output src_a, output src_b, output imm, output op, output fmt, input result);
    modport lanes (input src_a, input src_b, input imm, input op, input fmt, output result);
endinterface
`default_nettype wire

//--- vcc_lanes.sv
// parallel per-lane comparator array for all lane formats
`timescale 1ns/1ps
`default_nettype none
module vcc_lanes (
    vcc_cmp_if.lanes cmp
);
    import vcc_pkg::*;

    // ----------------------------------------------------------------
    // lane compare at 65 bits: narrower lanes are extended first
    // ----------------------------------------------------------------
    function automatic logic lane_cmp(vcc_op_t op, logic [64:0] a, logic [64:0] b);
        logic r;
        r = 1'b0;
        case (op)
            OP_EQ_IMM: r = (a == b);
            OP_CLE_S, OP_LE_S_IMM: r = ($signed(a) <= $signed(b));
            OP_CLE_U, OP_LE_U_IMM: r = ($signed(a) <= $signed(b));
            OP_LT_S: r = ($signed(a) < $signed(b));
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // extend a lane of width w to 65 bits, signed or zero
    function automatic logic [64:0] ext(logic [63:0] v, int w, logic sgn);
        logic [64:0] r;
        r = 65'h0;
        for (int k = 0; k < 65; k++) begin
            r[k] = (k < w) ? v[k] : (sgn & v[w-1]);
        end
        return r;
    endfunction

    // all lanes evaluated together, format picks one width per instruction
    always_comb begin
        logic sgn;
        logic use_imm;
        logic [63:0] imm64;
        logic [63:0] av;
        logic [63:0] bv;
        logic c;
        int w;
        sgn = 1'b0;
        use_imm = 1'b0;
        imm64 = 64'h0;
        av = 64'h0;
        bv = 64'h0;
        c = 1'b0;
        w = 8;
        cmp.result = '0;
        // unsigned ops zero-extend; immediate is signed or zero-extended
        sgn = (cmp.op == OP_EQ_IMM) || (cmp.op == OP_CLE_S) || (cmp.op == OP_LE_S_IMM)
            || (cmp.op == OP_LT_S);
        use_imm = (cmp.op == OP_EQ_IMM) || (cmp.op == OP_LE_S_IMM) || (cmp.op == OP_LE_U_IMM);
        imm64 = {{59{sgn & cmp.imm[4]}}, cmp.imm};
        case (cmp.fmt)
            FMT_BYTE: w = 8;
            FMT_HALF: w = 16;
            FMT_WORD: w = 32;
            default: w = 64;
        endcase
        // each lane independent, all ones or all zeros
        for (int i = 0; i < VEC_W / 8; i++) begin
            if ((i * 8) % w == 0) begin
                av = 64'h0;
                bv = 64'h0;
                for (int k = 0; k < 64; k++) begin
                    if (k < w) begin
                        av[k] = cmp.src_a[i*8+k];
                        bv[k] = use_imm ? imm64[k] : cmp.src_b[i*8+k];
                    end
                end
                c = lane_cmp(cmp.op, ext(av, w, sgn), ext(bv, w, sgn));
                for (int k = 0; k < 64; k++) begin
                    if (k < w) begin
                        cmp.result[i*8+k] = c;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- vcc_top.sv
// vector compare datapath and control register read path
`timescale 1ns/1ps
`default_nettype none
// Contract
// - equal-immediate sets lane ones on match
// - lanes compare independently, four formats
// - signed immediate sign-extended from bit four
// - signed vector less-or-equal compare
// - unsigned vector less-or-equal compare
// - signed immediate less-or-equal compare
// - unsigned immediate zero-extended, less-or-equal
// - signed vector strictly-less compare
// - compares never raise data exceptions
// - control read copies selected register
// - reserved selector reads zero
// - selectors two-seven need partitioning present
// - coprocessor zero disabled raises unusable on selectors two-seven with partitioning present
// - reserved-instruction and unit-disabled exceptions
module vcc_top (
    input wire logic clk,
    input wire logic srst,
    // compare request
    input wire logic cmp_valid,
    input wire vcc_pkg::vcc_op_t cmp_op,
    input wire vcc_pkg::vcc_fmt_t lane_data_format,
    input wire logic [vcc_pkg::VEC_W-1:0] first_source_vector,
    input wire logic [vcc_pkg::VEC_W-1:0] second_source_vector,
    input wire logic [vcc_pkg::IMM_W-1:0] cmp_imm,
    output logic cmp_done,
    output logic [vcc_pkg::VEC_W-1:0] destination_vector,
    // control register read request
    input wire logic rd_valid,
    input wire logic [vcc_pkg::SEL_W-1:0] rd_sel,
    input wire logic unit_enabled,
    input wire logic cop0_enabled,
    input wire logic insn_reserved,
    input wire logic [vcc_pkg::GPR_W-1:0] simd_implementation_info,
    input wire logic [vcc_pkg::GPR_W-1:0] partition_access_reg,
    input wire logic [vcc_pkg::GPR_W-1:0] partition_save_reg,
    input wire logic [vcc_pkg::GPR_W-1:0] partition_modify_reg,
    input wire logic [vcc_pkg::GPR_W-1:0] partition_request_reg,
    input wire logic [vcc_pkg::GPR_W-1:0] partition_map_reg,
    input wire logic [vcc_pkg::GPR_W-1:0] partition_unmap_reg,
    // control and status register write-in from the host
    input wire logic csr_wr,
    input wire logic [vcc_pkg::GPR_W-1:0] csr_wdata,
    output logic [vcc_pkg::GPR_W-1:0] simd_control_status,
    // read answer
    output logic rd_done,
    output logic [vcc_pkg::GPR_W-1:0] rd_data,
    output logic exc_reserved,
    output logic exc_unit_disabled,
    output logic exc_cop_unusable,
    output logic cmp_exception
);
    import vcc_pkg::*;

    // ----------------------------------------------------------------
    // compare datapath
    // ----------------------------------------------------------------
    vcc_cmp_if cmp_bus ();
    vcc_lanes u_lanes (
        .cmp(cmp_bus)
    );

    // drive the lane array straight from the request
    always_comb begin
        cmp_bus.src_a = first_source_vector;
        cmp_bus.src_b = second_source_vector;
        cmp_bus.imm = cmp_imm;
        cmp_bus.op = cmp_op;
        cmp_bus.fmt = lane_data_format;
    end

    logic [VEC_W-1:0] dst_ff;
    logic [VEC_W-1:0] nxt_dst;
    logic cmp_done_ff;
    logic nxt_cmp_done;

    // result captured one cycle after the request, held until next one
    always_comb begin
        nxt_dst = dst_ff;
        nxt_cmp_done = cmp_valid;
        if (cmp_valid) begin
            nxt_dst = cmp_bus.result;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dst_ff <= '0;
            cmp_done_ff <= 1'b0;
        end else begin
            dst_ff <= nxt_dst;
            cmp_done_ff <= nxt_cmp_done;
        end
    end

    assign destination_vector = dst_ff;
    assign cmp_done = cmp_done_ff;
    // no data-dependent fault path exists in the compare unit
    assign cmp_exception = 1'b0;

    // ----------------------------------------------------------------
    // control and status register
    // ----------------------------------------------------------------
    logic [GPR_W-1:0] csr_ff;
    logic [GPR_W-1:0] nxt_csr;

    always_comb begin
        nxt_csr = csr_wr ? csr_wdata : csr_ff;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            csr_ff <= CSR_RST;
        end else begin
            csr_ff <= nxt_csr;
        end
    end

    assign simd_control_status = csr_ff;

    // ----------------------------------------------------------------
    // control register read path
    // ----------------------------------------------------------------
    vcc_rd_state_t rd_state_ff;
    vcc_rd_state_t nxt_rd_state;
    logic [GPR_W-1:0] rd_data_ff;
    logic [GPR_W-1:0] nxt_rd_data;
    logic [2:0] exc_ff;
    logic [2:0] nxt_exc;
    logic part_present;
    logic sel_part;

    assign part_present = simd_implementation_info[PART_BIT];
    assign sel_part = (rd_sel >= SEL_ACCESS) && (rd_sel <= SEL_UNMAP);

    // read mux and exception priority: reserved, disabled, then cop0
    always_comb begin
        nxt_rd_state = RD_IDLE;
        nxt_rd_data = rd_data_ff;
        nxt_exc = 3'h0;
        case (rd_state_ff)
            RD_IDLE, RD_DONE: begin
                if (rd_valid) begin
                    nxt_rd_state = RD_DONE;
                    nxt_rd_data = ZERO_WORD;
                    if (insn_reserved) begin
                        nxt_exc = 3'b001;
                    end else if (!unit_enabled) begin
                        nxt_exc = 3'b010;
                    end else if (part_present && sel_part && !cop0_enabled) begin
                        nxt_exc = 3'b100;
                    end else begin
                        case (rd_sel)
                            SEL_INFO: nxt_rd_data = simd_implementation_info;
                            SEL_CSR: nxt_rd_data = csr_ff;
                            SEL_ACCESS: nxt_rd_data = partition_access_reg;
                            SEL_SAVE: nxt_rd_data = partition_save_reg;
                            SEL_MODIFY: nxt_rd_data = partition_modify_reg;
                            SEL_REQUEST: nxt_rd_data = partition_request_reg;
                            SEL_MAP: nxt_rd_data = partition_map_reg;
                            SEL_UNMAP: nxt_rd_data = partition_unmap_reg;
                            default: nxt_rd_data = ZERO_WORD;
                        endcase
                        // partition registers read as zero when partitioning is absent
                        if (sel_part && !part_present) begin
                            nxt_rd_data = ZERO_WORD;
                        end
                    end
                end
            end
            default: nxt_rd_state = RD_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rd_state_ff <= RD_IDLE;
            rd_data_ff <= ZERO_WORD;
            exc_ff <= 3'h0;
        end else begin
            rd_state_ff <= nxt_rd_state;
            rd_data_ff <= nxt_rd_data;
            exc_ff <= nxt_exc;
        end
    end

    assign rd_done = (rd_state_ff == RD_DONE);
    assign rd_data = rd_data_ff;
    assign exc_reserved = exc_ff[0];
    assign exc_unit_disabled = exc_ff[1];
    assign exc_cop_unusable = exc_ff[2];

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_cmp_latency: assert property (@(posedge clk) disable iff (srst)
        cmp_valid |=> cmp_done && destination_vector == $past(cmp_bus.result))
        else $error("compare result not captured one cycle later");
    a_eq_imm_match: assert property (@(posedge clk) disable iff (srst)
        cmp_valid && cmp_op == OP_EQ_IMM && lane_data_format == FMT_BYTE
        && first_source_vector[7:0] == {{3{cmp_imm[4]}}, cmp_imm}
        |=> destination_vector[7:0] == 8'hff)
        else $error("equal immediate lane not set");
    a_clt_self: assert property (@(posedge clk) disable iff (srst)
        cmp_valid && cmp_op == OP_LT_S && first_source_vector == second_source_vector
        |=> destination_vector == '0)
        else $error("strict less-than true on equal operands");
    a_cle_self: assert property (@(posedge clk) disable iff (srst)
        cmp_valid && (cmp_op == OP_CLE_S || cmp_op == OP_CLE_U)
        && first_source_vector == second_source_vector |=> destination_vector == '1)
        else $error("less-or-equal false on equal operands");
    a_cleu_zero: assert property (@(posedge clk) disable iff (srst)
        cmp_valid && cmp_op == OP_LE_U_IMM && first_source_vector == '0
        |=> destination_vector == '1)
        else $error("zero not below unsigned immediate");
    a_no_cmp_exc: assert property (@(posedge clk) disable iff (srst)
        cmp_done |-> !cmp_exception)
        else $error("compare raised exception");
    a_rd_info: assert property (@(posedge clk) disable iff (srst)
        rd_valid && rd_sel == SEL_INFO && !insn_reserved && unit_enabled
        |=> rd_done && rd_data == $past(simd_implementation_info))
        else $error("info register read wrong");
    a_rd_nopart: assert property (@(posedge clk) disable iff (srst)
        rd_valid && sel_part && !part_present |=> rd_data == ZERO_WORD && !exc_cop_unusable)
        else $error("partition read without partitioning not zero");
    a_rd_cop0: assert property (@(posedge clk) disable iff (srst)
        rd_valid && sel_part && part_present && !cop0_enabled && !insn_reserved
        && unit_enabled |=> exc_cop_unusable)
        else $error("cop0 unusable not raised");
    a_rd_resv: assert property (@(posedge clk) disable iff (srst)
        rd_valid && rd_sel > SEL_UNMAP |=> rd_data == ZERO_WORD)
        else $error("reserved selector not zero");
endmodule
`default_nettype wire

//--- vcc_host_model.sv
// host core model supplying implementation info and partition registers
`timescale 1ns/1ps
`default_nettype none
module vcc_host_model (
    input wire logic part_present,
    output logic [31:0] info_word,
    output logic [31:0] access_word,
    output logic [31:0] save_word,
    output logic [31:0] modify_word,
    output logic [31:0] request_word,
    output logic [31:0] map_word,
    output logic [31:0] unmap_word
);
    // ------------------------------------------------------------
    // register contents
    // ------------------------------------------------------------
    // base value is arbitrary; only the partitioning bit carries meaning
    localparam logic [31:0] INFO_BASE = 32'h0000_0a5c;
    // distinct words so a wrong selector shows up as a wrong value
    assign info_word = INFO_BASE | ({31'h0, part_present} << 17);
    assign access_word = 32'h1111_2222;
    assign save_word = 32'h3333_4444;
    assign modify_word = 32'h5555_6666;
    assign request_word = 32'h7777_8888;
    assign map_word = 32'h9999_aaaa;
    assign unmap_word = 32'hbbbb_cccc;
endmodule
`default_nettype wire

//--- vcc_top_test.sv
// self-checking testbench for the vector compare and control read block
`timescale 1ns/1ps
`default_nettype none
module vcc_top_test;
    import vcc_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cmp_valid = 1'b0, rd_valid = 1'b0, csr_wr = 1'b0;
    vcc_op_t cmp_op = OP_EQ_IMM;
    vcc_fmt_t fmt = FMT_BYTE;
    logic [VEC_W-1:0] src_a = '0, src_b = '0, dst;
    logic [IMM_W-1:0] imm = '0;
    logic [SEL_W-1:0] rd_sel = '0;
    logic unit_en = 1'b1, cop0_en = 1'b1, insn_res = 1'b0, part = 1'b1;
    logic [GPR_W-1:0] csr_wdata = '0, csr_exp = '0, csr_q, rd_data;
    logic [GPR_W-1:0] info, r2, r3, r4, r5, r6, r7;
    logic cmp_done, rd_done, e_res, e_dis, e_cop, cmp_exc;
    int err_count = 0, check_count = 0;
    // boundary patterns: sign bit set, max positive, equal lanes, immediates
    logic [127:0] pa [2] = '{128'hffffffffffffffff_800000000000000f,
        128'h0f0ff0f01010efef_0000ffff7f801f10};
    logic [127:0] pb [2] = '{128'h0000000000000000_7fffffff0000000f,
        128'h0f10f0ef0f10f0ef_ffff0000807f1f0f};
    logic [4:0] imms [4] = '{5'h1f, 5'h0f, 5'h10, 5'h00};

    always #25 clk = ~clk;

    vcc_host_model HOST (.part_present(part), .info_word(info), .access_word(r2),
        .save_word(r3), .modify_word(r4), .request_word(r5), .map_word(r6), .unmap_word(r7));

    vcc_top DUT (.clk(clk), .srst(srst), .cmp_valid(cmp_valid), .cmp_op(cmp_op),
        .lane_data_format(fmt), .first_source_vector(src_a), .second_source_vector(src_b),
        .cmp_imm(imm), .cmp_done(cmp_done), .destination_vector(dst), .rd_valid(rd_valid),
        .rd_sel(rd_sel), .unit_enabled(unit_en), .cop0_enabled(cop0_en),
        .insn_reserved(insn_res), .simd_implementation_info(info),
        .partition_access_reg(r2), .partition_save_reg(r3), .partition_modify_reg(r4),
        .partition_request_reg(r5), .partition_map_reg(r6), .partition_unmap_reg(r7),
        .csr_wr(csr_wr), .csr_wdata(csr_wdata), .simd_control_status(csr_q),
        .rd_done(rd_done), .rd_data(rd_data), .exc_reserved(e_res),
        .exc_unit_disabled(e_dis), .exc_cop_unusable(e_cop), .cmp_exception(cmp_exc));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // lane-by-lane reference, 64-bit working width covers every format
    function automatic logic [127:0] exp_cmp(input vcc_op_t o, input vcc_fmt_t f,
        input logic [127:0] a, input logic [127:0] b, input logic [4:0] i);
        int w;
        logic [63:0] m, x, y;
        longint xs, ys, si;
        logic c;
        logic [127:0] r;
        w = 8 << f;
        m = (64'h1 << w) - 64'h1;
        si = {{59{i[4]}}, i};
        r = '0;
        for (int k = 0; k < 128 / w; k++) begin
            x = 64'(a >> (w * k)) & m;
            y = 64'(b >> (w * k)) & m;
            xs = x[w-1] ? (x | ~m) : x;
            ys = y[w-1] ? (y | ~m) : y;
            case (o)
                OP_EQ_IMM: c = (xs == si);
                OP_CLE_S: c = (xs <= ys);
                OP_CLE_U: c = (x <= y);
                OP_LE_S_IMM: c = (xs <= si);
                OP_LE_U_IMM: c = (x <= {59'h0, i});
                default: c = (xs < ys);
            endcase
            r = r | (({128{c}} & {64'h0, m}) << (w * k));
        end
        return r;
    endfunction

    task automatic do_cmp(input vcc_op_t o, input vcc_fmt_t f, input logic [127:0] a,
        input logic [127:0] b, input logic [4:0] i);
        @(posedge clk);
        cmp_op <= o;
        fmt <= f;
        src_a <= a;
        src_b <= b;
        imm <= i;
        cmp_valid <= 1'b1;
        @(posedge clk);
        cmp_valid <= 1'b0;
        #1;
        check("cmp_done", cmp_done, 1'b1);
        check("destination_vector", dst, exp_cmp(o, f, a, b, i));
        check("cmp_exception", cmp_exc, 1'b0);
    endtask

    // r: reserved instruction, u: unit enabled; priority follows the read path
    task automatic do_rd(input logic [4:0] s, input logic p, input logic c, input logic r,
        input logic u);
        logic er, ed, ec;
        logic [31:0] d;
        @(posedge clk);
        rd_sel <= s;
        part <= p;
        cop0_en <= c;
        insn_res <= r;
        unit_en <= u;
        rd_valid <= 1'b1;
        @(posedge clk);
        rd_valid <= 1'b0;
        #1;
        er = r;
        ed = !r && !u;
        ec = !r && u && p && s >= 2 && s <= 7 && !c;
        case (s)
            5'h00: d = info;
            5'h01: d = csr_exp;
            5'h02: d = r2;
            5'h03: d = r3;
            5'h04: d = r4;
            5'h05: d = r5;
            5'h06: d = r6;
            5'h07: d = r7;
            default: d = '0;
        endcase
        if (er || ed || ec || (s > 1 && !p))
            d = '0;
        check("rd_done", rd_done, 1'b1);
        check("rd_data", rd_data, d);
        check("read exception flags", {e_res, e_dis, e_cop}, {er, ed, ec});
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        check("simd_control_status", csr_q, CSR_RST);
        // every op, format and immediate over both patterns
        for (int pt = 0; pt < 2; pt++)
            for (int o = 0; o < 6; o++)
                for (int f = 0; f < 4; f++)
                    for (int k = 0; k < 4; k++)
                        do_cmp(vcc_op_t'(o), vcc_fmt_t'(f), pa[pt], pb[pt],
                            imms[k]);
        @(posedge clk);
        csr_wr <= 1'b1;
        csr_wdata <= 32'h0000_0f83;
        @(posedge clk);
        csr_wr <= 1'b0;
        #1;
        csr_exp = 32'h0000_0f83;
        check("simd_control_status", csr_q, csr_exp);
        // selectors zero to nine with partitioning and coprocessor 0 both ways
        for (int p = 0; p < 2; p++)
            for (int c = 0; c < 2; c++)
                for (int s = 0; s < 10; s++)
                    do_rd(5'(s), p[0], c[0], 1'b0, 1'b1);
        do_rd(5'h1f, 1'b1, 1'b1, 1'b0, 1'b1);
        do_rd(5'h00, 1'b1, 1'b1, 1'b1, 1'b1);
        do_rd(5'h02, 1'b1, 1'b0, 1'b0, 1'b0);
        do_rd(5'h01, 1'b1, 1'b0, 1'b1, 1'b0);
        report_and_stop();
    end

    // hang guard: the run needs well under 1000 cycles
    initial begin
        #100000;
        err_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
